// file: core/cfsb_bank.sv
// Latched fault and warning status bank of a stackable buck converter.
// Assumes the command decoder hands over byte reads and writes already
// parsed, with a one-cycle strobe; fault detectors drive pulses or levels.
`timescale 1ns/1ns

// Notes on behaviour
// [RULE1] Each register is one byte read or one byte written per transaction.
// [RULE2] Latched bits clear by clear-faults or by writing one; zero writes hold.
// [RULE3] Output current: overcurrent fault bit7, warning bit5, undercurrent fault bit4.
// [RULE4] Output current bits 6 and 3:0 ignore writes and read zero.
// [RULE5] Input: overvoltage fault bit7, overvoltage warning bit6, undervoltage warning bit5.
// [RULE6] Input bit 3 is live: one while the power input is off.
// [RULE7] Live input-off is set when input below turn-on or aux supply in lockout.
// [RULE8] Input-off shows from reset and never raises the alert.
// [RULE9] Undervoltage warning alert stays masked until input first passes turn-on.
// [RULE10] Input bits 4 and 2:0 read zero.
// [RULE11] Temperature: fault bit7, warning bit6, bits 5:0 read zero.
// [RULE12] Communication bit7 latches on an invalid command code.
// [RULE13] Communication bit6 latches on invalid data with a command.
// [RULE14] Communication bit5 latches on a packet error check failure.
// [RULE15] Communication bit4 latches memory errors, bit3 logic core errors.
// [RULE16] Communication bit1 latches other errors; bits 2 and 0 read zero.
// [RULE17] Each alert-capable bit has a mask bit that blocks its alert.
// [RULE18] A secondary reports back-channel trouble as a communication fault.
// [RULE19] Status byte communication summary is the OR of communication bits.
// [RULE20] Latched bits stay set after the cause goes until cleared.
module cfsb_bank
  import cfsb_pkg::*;
(
  input  wire logic       REF_CLK_IN,          // 100 MHz core clock
  input  wire logic       NRST_IN,             // Async reset, active low
  input  wire logic       WR_STB_IN,           // Write byte strobe
  input  wire logic       RD_STB_IN,           // Read byte strobe
  input  wire logic [7:0] CMD_CODE_IN,         // Command code
  input  wire logic [7:0] WR_DATA_IN,          // Write data byte
  input  wire logic       CLEAR_FAULTS_IN,     // Global clear pulse
  input  wire logic [7:0] MASK_WR_CODE_IN,     // Register the mask write targets
  input  wire logic [7:0] MASK_WR_DATA_IN,     // Mask byte
  input  wire logic       MASK_WR_STB_IN,      // Mask write strobe
  input  wire logic       OUT_OC_FAULT_IN,     // Overcurrent fault event
  input  wire logic       OUT_OC_WARN_IN,      // Overcurrent warning event
  input  wire logic       OUT_UC_FAULT_IN,     // Undercurrent fault event
  input  wire logic       IN_OV_FAULT_IN,      // Input overvoltage fault event
  input  wire logic       IN_OV_WARN_IN,       // Input overvoltage warning event
  input  wire logic       IN_UV_WARN_IN,       // Input undervoltage warning event
  input  wire logic       INPUT_ABOVE_ON_IN,   // Power input above turn-on, async
  input  wire logic       AUX_FIVE_UVLO_IN,    // Aux 5 V supply in lockout, async
  input  wire logic       OT_FAULT_IN,         // Overtemperature fault event
  input  wire logic       OT_WARN_IN,          // Overtemperature warning event
  input  wire logic       BAD_COMMAND_IN,      // Invalid command code event
  input  wire logic       BAD_DATA_IN,         // Invalid data event
  input  wire logic       PEC_FAIL_IN,         // Packet check failure event
  input  wire logic       MEM_ERROR_IN,        // Memory error event
  input  wire logic       CORE_ERROR_IN,       // Logic core error event
  input  wire logic       OTHER_OTHER_ERROR_FLAG_A_ERROR_IN, // Other other_error_flag_a error event
  input  wire logic       BACK_CHANNEL_ERR_IN, // Back-channel error event
  input  wire logic       IS_SECONDARY_IN,     // Device is a stack secondary
  output logic [7:0]      RD_DATA_OUT,         // Read data byte
  output logic            RD_VALID_OUT,        // Read data valid pulse
  output logic            ALERT_OUT,           // Alert request, active high
  output logic            OTHER_ERROR_FLAG_A_SUMMARY_OUT     // Status byte other_error_flag_a bit
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] out_current_status;
  logic [7:0] input_supply_status;
  logic [7:0] die_temp_status;
  logic [7:0] other_error_flag_a_logic_status;
  logic [7:0] mask_out_current;
  logic [7:0] mask_input;
  logic [7:0] mask_temp;
  logic [7:0] mask_other_error_flag_a;
  logic       uv_armed;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       alert;
  logic       other_error_flag_a_summary;

  logic [7:0] next_out_current_status;
  logic [7:0] next_input_supply_status;
  logic [7:0] next_die_temp_status;
  logic [7:0] next_other_error_flag_a_logic_status;
  logic [7:0] next_mask_out_current;
  logic [7:0] next_mask_input;
  logic [7:0] next_mask_temp;
  logic [7:0] next_mask_other_error_flag_a;
  logic       next_uv_armed;
  logic [7:0] next_rd_data;
  logic       next_rd_valid;
  logic       next_alert;
  logic       next_other_error_flag_a_summary;

  logic       input_above_on;
  logic       aux_uvlo;
  logic       input_off_indication;

  // ----------------------------------------------------------------
  // Synchronised live inputs
  // ----------------------------------------------------------------
  cfsb_sync u_sync_on (
    .clk_in    (REF_CLK_IN),
    .nrst_in   (NRST_IN),
    .async_in  (INPUT_ABOVE_ON_IN),
    .level_out (input_above_on)
  );

  cfsb_sync u_sync_aux (
    .clk_in    (REF_CLK_IN),
    .nrst_in   (NRST_IN),
    .async_in  (AUX_FIVE_UVLO_IN),
    .level_out (aux_uvlo)
  );

  // Off from reset until input is seen above turn-on and aux is good
  assign input_off_indication = !input_above_on || aux_uvlo; // see [RULE7] see [RULE8]

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Set wins over clear; write-one clears, write-zero holds
  function automatic logic [7:0] latch_update(
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic [7:0] supported,
    input logic       wr_hit,
    input logic [7:0] wdata,
    input logic       clr_all
  );
    logic [7:0] clr;
    clr = clr_all ? 8'hFF : (wr_hit ? wdata : 8'h00);       // see [RULE2]
    return ((cur & ~clr) | set) & supported;                 // see [RULE20]
  endfunction

  function automatic logic [7:0] mask_update(
    input logic [7:0] cur,
    input logic       hit,
    input logic [7:0] wdata,
    input logic [7:0] supported
  );
    return hit ? (wdata & supported) : cur;
  endfunction

  // One-hot register select from a command code; zero when unmapped
  function automatic logic [3:0] reg_select(
    input logic [7:0] code
  );
    logic [3:0] sel;
    sel = 4'h0;
    if (code == CMD_OUT_CURRENT) begin
      sel[0] = 1'b1;
    end else if (code == CMD_INPUT_SUPPLY) begin
      sel[1] = 1'b1;
    end else if (code == CMD_DIE_TEMP) begin
      sel[2] = 1'b1;
    end else if (code == CMD_OTHER_ERROR_FLAG_A_LOGIC) begin
      sel[3] = 1'b1;
    end
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // Status latches
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] set_oc;
    logic [7:0] set_in;
    logic [7:0] set_ot;
    logic [7:0] set_cm;
    logic [3:0] wsel;
    set_oc = 8'h00;
    set_in = 8'h00;
    set_ot = 8'h00;
    set_cm = 8'h00;
    wsel   = reg_select(CMD_CODE_IN);
    set_oc[BIT_OUT_OVERCURRENT_FAULT]   = OUT_OC_FAULT_IN;   // see [RULE3]
    set_oc[BIT_OUT_OVERCURRENT_WARNING] = OUT_OC_WARN_IN;
    set_oc[BIT_OUT_UNDERCURRENT_FAULT]  = OUT_UC_FAULT_IN;
    set_in[BIT_INPUT_OV_FAULT]          = IN_OV_FAULT_IN;    // see [RULE5]
    set_in[BIT_INPUT_OV_WARNING]        = IN_OV_WARN_IN;
    set_in[BIT_INPUT_UV_WARNING]        = IN_UV_WARN_IN;
    set_ot[BIT_OVERTEMP_FAULT]          = OT_FAULT_IN;       // see [RULE11]
    set_ot[BIT_OVERTEMP_WARNING]        = OT_WARN_IN;
    set_cm[BIT_BAD_COMMAND]             = BAD_COMMAND_IN;    // see [RULE12]
    set_cm[BIT_BAD_DATA]                = BAD_DATA_IN;       // see [RULE13]
    set_cm[BIT_PACKET_CHECK]            = PEC_FAIL_IN;       // see [RULE14]
    set_cm[BIT_MEMORY_ERROR]            = MEM_ERROR_IN;      // see [RULE15]
    set_cm[BIT_LOGIC_CORE_ERROR]        = CORE_ERROR_IN;
    set_cm[BIT_OTHER_ERROR_A]           = OTHER_OTHER_ERROR_FLAG_A_ERROR_IN
                                        | (IS_SECONDARY_IN & BACK_CHANNEL_ERR_IN); // see [RULE16] see [RULE18]

    // Unsupported bits are forced to zero and ignore writes
    next_out_current_status = latch_update(out_current_status, set_oc, MASK_OUT_CURRENT,
      WR_STB_IN && wsel[0], WR_DATA_IN, CLEAR_FAULTS_IN); // see [RULE4]
    next_input_supply_status = latch_update(input_supply_status, set_in, MASK_INPUT_LATCH,
      WR_STB_IN && wsel[1], WR_DATA_IN, CLEAR_FAULTS_IN); // see [RULE10]
    next_die_temp_status = latch_update(die_temp_status, set_ot, MASK_DIE_TEMP,
      WR_STB_IN && wsel[2], WR_DATA_IN, CLEAR_FAULTS_IN);
    next_other_error_flag_a_logic_status = latch_update(other_error_flag_a_logic_status, set_cm, MASK_OTHER_ERROR_FLAG_A_LOGIC,
      WR_STB_IN && wsel[3], WR_DATA_IN, CLEAR_FAULTS_IN);

    // Undervoltage warning alert armed once input first exceeds turn-on
    next_uv_armed = uv_armed | input_above_on;                // see [RULE9]
  end

  // ----------------------------------------------------------------
  // Alert masks
  // ----------------------------------------------------------------
  always_comb begin
    logic       hit;
    logic [3:0] msel;
    hit  = MASK_WR_STB_IN;
    msel = reg_select(MASK_WR_CODE_IN);
    next_mask_out_current = mask_update(mask_out_current,
      hit && msel[0], MASK_WR_DATA_IN, MASK_OUT_CURRENT); // see [RULE17]
    next_mask_input = mask_update(mask_input,
      hit && msel[1], MASK_WR_DATA_IN, MASK_INPUT_LATCH);
    next_mask_temp = mask_update(mask_temp,
      hit && msel[2], MASK_WR_DATA_IN, MASK_DIE_TEMP);
    next_mask_other_error_flag_a = mask_update(mask_other_error_flag_a,
      hit && msel[3], MASK_WR_DATA_IN, MASK_OTHER_ERROR_FLAG_A_LOGIC);
  end

  // ----------------------------------------------------------------
  // Read port, alert and summary
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] in_read;
    logic [7:0] in_alert;
    in_read = input_supply_status;
    in_read[BIT_INPUT_OFF_INDICATION] = input_off_indication;  // see [RULE6]
    // Reads see the registers as they stood before a same-cycle write
    next_rd_valid = RD_STB_IN;                                 // see [RULE1]
    next_rd_data  = rd_data;
    if (RD_STB_IN) begin
      if (CMD_CODE_IN == CMD_OUT_CURRENT) begin
        next_rd_data = out_current_status;
      end else if (CMD_CODE_IN == CMD_INPUT_SUPPLY) begin
        next_rd_data = in_read;
      end else if (CMD_CODE_IN == CMD_DIE_TEMP) begin
        next_rd_data = die_temp_status;
      end else if (CMD_CODE_IN == CMD_OTHER_ERROR_FLAG_A_LOGIC) begin
        next_rd_data = other_error_flag_a_logic_status;
      end else begin
        next_rd_data = 8'h00;
      end
    end
    // Input-off never reaches the alert; undervoltage needs arming
    in_alert = input_supply_status & ~mask_input;              // see [RULE8]
    if (!uv_armed) begin
      in_alert[BIT_INPUT_UV_WARNING] = 1'b0;                   // see [RULE9]
    end
    next_alert = |(out_current_status & ~mask_out_current)
               | |in_alert
               | |(die_temp_status & ~mask_temp)
               | |(other_error_flag_a_logic_status & ~mask_other_error_flag_a);            // see [RULE17]
    // Summary moves in the same cycle as the status it summarises
    next_other_error_flag_a_summary = |next_other_error_flag_a_logic_status;               // see [RULE19]
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      out_current_status  <= RESET_STATUS;
      input_supply_status <= RESET_STATUS;
      die_temp_status     <= RESET_STATUS;
      other_error_flag_a_logic_status   <= RESET_STATUS;
      mask_out_current    <= RESET_ALERT_MASK;
      mask_input          <= RESET_ALERT_MASK;
      mask_temp           <= RESET_ALERT_MASK;
      mask_other_error_flag_a           <= RESET_ALERT_MASK;
      uv_armed            <= 1'b0;
      rd_data             <= 8'h00;
      rd_valid            <= 1'b0;
      alert               <= 1'b0;
      other_error_flag_a_summary        <= 1'b0;
    end else begin
      out_current_status  <= next_out_current_status;
      input_supply_status <= next_input_supply_status;
      die_temp_status     <= next_die_temp_status;
      other_error_flag_a_logic_status   <= next_other_error_flag_a_logic_status;
      mask_out_current    <= next_mask_out_current;
      mask_input          <= next_mask_input;
      mask_temp           <= next_mask_temp;
      mask_other_error_flag_a           <= next_mask_other_error_flag_a;
      uv_armed            <= next_uv_armed;
      rd_data             <= next_rd_data;
      rd_valid            <= next_rd_valid;
      alert               <= next_alert;
      other_error_flag_a_summary        <= next_other_error_flag_a_summary;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RD_DATA_OUT      = rd_data;
  assign RD_VALID_OUT     = rd_valid;
  assign ALERT_OUT        = alert;
  assign OTHER_ERROR_FLAG_A_SUMMARY_OUT = other_error_flag_a_summary;

endmodule

// file: core/cfsb_pkg.sv
// Package for the converter fault status bank.
// Assumes one 100 MHz core clock; no timing counts are needed.
package cfsb_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OUT_CURRENT  = 8'h7B;
  localparam logic [7:0] CMD_INPUT_SUPPLY = 8'h7C;
  localparam logic [7:0] CMD_DIE_TEMP     = 8'h7D;
  localparam logic [7:0] CMD_OTHER_ERROR_FLAG_A_LOGIC   = 8'h7E;

  // ----------------------------------------------------------------
  // Supported bit masks per register
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_OUT_CURRENT  = 8'hB0;
  localparam logic [7:0] MASK_INPUT_LATCH  = 8'hE0;
  localparam logic [7:0] MASK_DIE_TEMP     = 8'hC0;
  localparam logic [7:0] MASK_OTHER_ERROR_FLAG_A_LOGIC   = 8'hFA;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_OUT_OVERCURRENT_FAULT   = 7;
  localparam int BIT_OUT_OVERCURRENT_WARNING = 5;
  localparam int BIT_OUT_UNDERCURRENT_FAULT  = 4;
  localparam int BIT_INPUT_OV_FAULT          = 7;
  localparam int BIT_INPUT_OV_WARNING        = 6;
  localparam int BIT_INPUT_UV_WARNING        = 5;
  localparam int BIT_INPUT_OFF_INDICATION    = 3;
  localparam int BIT_OVERTEMP_FAULT          = 7;
  localparam int BIT_OVERTEMP_WARNING        = 6;
  localparam int BIT_BAD_COMMAND             = 7;
  localparam int BIT_BAD_DATA                = 6;
  localparam int BIT_PACKET_CHECK            = 5;
  localparam int BIT_MEMORY_ERROR            = 4;
  localparam int BIT_LOGIC_CORE_ERROR        = 3;
  localparam int BIT_OTHER_ERROR_A           = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_STATUS     = 8'h00;
  localparam logic [7:0] RESET_ALERT_MASK = 8'h00;
  localparam logic [2:0] SYNC_RESET       = 3'h0;

endpackage

// file: core/cfsb_sync.sv
// Three-stage synchroniser for one asynchronous level.
// Assumes the level comes from outside the clock domain.
`timescale 1ns/1ns
module cfsb_sync
  import cfsb_pkg::*;
(
  input  wire logic clk_in,   // Core clock
  input  wire logic nrst_in,  // Async reset, active low
  input  wire logic async_in, // Level from outside
  output logic      level_out // Filtered level
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       level;
  logic       next_level;

  assign level_out = level;

  always_comb begin
    next_stage = {stage[1:0], async_in};
    next_level = level;
    // Change counts once the second and third stages agree
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage <= SYNC_RESET;
      level <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

endmodule

// file: dv/cfsb_bank_properties.sv
// Assertion checker for the fault status bank.
// Assumes it is bound to cfsb_bank and sees only its ports.
`timescale 1ns/1ns
module cfsb_bank_properties
  import cfsb_pkg::*;
(
  input wire logic       REF_CLK_IN,          // Clock
  input wire logic       NRST_IN,             // Reset
  input wire logic       RD_STB_IN,           // Read
  input wire logic       WR_STB_IN,           // Write
  input wire logic       CLEAR_FAULTS_IN,     // Clear
  input wire logic [7:0] CMD_CODE_IN,         // Code
  input wire logic [7:0] WR_DATA_IN,          // Data
  input wire logic       OUT_OC_FAULT_IN,     // Event
  input wire logic       OUT_OC_WARN_IN,      // Event
  input wire logic       OUT_UC_FAULT_IN,     // Event
  input wire logic       BAD_COMMAND_IN,      // Event
  input wire logic       BAD_DATA_IN,         // Event
  input wire logic       PEC_FAIL_IN,         // Event
  input wire logic       MEM_ERROR_IN,        // Event
  input wire logic       CORE_ERROR_IN,       // Event
  input wire logic       OTHER_OTHER_ERROR_FLAG_A_ERROR_IN, // Event
  input wire logic       BACK_CHANNEL_ERR_IN, // Event
  input wire logic       IS_SECONDARY_IN,     // Secondary
  input wire logic [7:0] RD_DATA_OUT,         // Read byte
  input wire logic       RD_VALID_OUT,        // Valid
  input wire logic       OTHER_ERROR_FLAG_A_SUMMARY_OUT     // Summary
);
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  logic out_ev;
  logic other_error_flag_a_ev;
  assign out_ev  = OUT_OC_FAULT_IN | OUT_OC_WARN_IN | OUT_UC_FAULT_IN;
  assign other_error_flag_a_ev = BAD_COMMAND_IN | BAD_DATA_IN | PEC_FAIL_IN | MEM_ERROR_IN | CORE_ERROR_IN
                 | OTHER_OTHER_ERROR_FLAG_A_ERROR_IN | (BACK_CHANNEL_ERR_IN & IS_SECONDARY_IN);
  sequence s_rd(logic [7:0] c);
    RD_STB_IN && CMD_CODE_IN == c;
  endsequence
  sequence s_wipe(logic go);
    (go && !out_ev) ##1 !out_ev ##1 (RD_STB_IN && CMD_CODE_IN == CMD_OUT_CURRENT && !out_ev);
  endsequence
  a_read_gives_valid: assert property (RD_STB_IN |=> RD_VALID_OUT)
    else $error("read not answered");
  a_no_stray_valid: assert property (!RD_STB_IN |=> !RD_VALID_OUT)
    else $error("valid without read");
  a_current_zero_bits: assert property (s_rd(CMD_OUT_CURRENT) |=> !(|(RD_DATA_OUT & 8'h4F)))
    else $error("current unsupported bit set");
  a_input_zero_bits: assert property (s_rd(CMD_INPUT_SUPPLY) |=> !(|(RD_DATA_OUT & 8'h17)))
    else $error("input unsupported bit set");
  a_temp_zero_bits: assert property (s_rd(CMD_DIE_TEMP) |=> !(|(RD_DATA_OUT & 8'h3F)))
    else $error("temperature unsupported bit set");
  a_other_error_flag_a_zero_bits: assert property (s_rd(CMD_OTHER_ERROR_FLAG_A_LOGIC) |=> !(|(RD_DATA_OUT & 8'h05)))
    else $error("other_error_flag_a unsupported bit set");
  a_summary_sets: assert property (other_error_flag_a_ev |=> OTHER_ERROR_FLAG_A_SUMMARY_OUT)
    else $error("summary did not set");
  a_summary_clears: assert property (CLEAR_FAULTS_IN && !other_error_flag_a_ev |=> !OTHER_ERROR_FLAG_A_SUMMARY_OUT)
    else $error("summary did not clear");
  a_write_one_wipes: assert property (s_wipe(WR_STB_IN && CMD_CODE_IN == CMD_OUT_CURRENT
    && WR_DATA_IN == 8'hFF) |=> RD_DATA_OUT == 8'h00) else $error("write one left bits");
  a_clear_wipes: assert property (s_wipe(CLEAR_FAULTS_IN) |=> RD_DATA_OUT == 8'h00)
    else $error("clear left bits");
endmodule
bind cfsb_bank cfsb_bank_properties u_props (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN),
  .RD_STB_IN(RD_STB_IN), .WR_STB_IN(WR_STB_IN), .CLEAR_FAULTS_IN(CLEAR_FAULTS_IN),
  .CMD_CODE_IN(CMD_CODE_IN), .WR_DATA_IN(WR_DATA_IN), .OUT_OC_FAULT_IN(OUT_OC_FAULT_IN),
  .OUT_OC_WARN_IN(OUT_OC_WARN_IN), .OUT_UC_FAULT_IN(OUT_UC_FAULT_IN),
  .BAD_COMMAND_IN(BAD_COMMAND_IN), .BAD_DATA_IN(BAD_DATA_IN), .PEC_FAIL_IN(PEC_FAIL_IN),
  .MEM_ERROR_IN(MEM_ERROR_IN), .CORE_ERROR_IN(CORE_ERROR_IN),
  .OTHER_OTHER_ERROR_FLAG_A_ERROR_IN(OTHER_OTHER_ERROR_FLAG_A_ERROR_IN), .BACK_CHANNEL_ERR_IN(BACK_CHANNEL_ERR_IN),
  .IS_SECONDARY_IN(IS_SECONDARY_IN), .RD_DATA_OUT(RD_DATA_OUT), .RD_VALID_OUT(RD_VALID_OUT),
  .OTHER_ERROR_FLAG_A_SUMMARY_OUT(OTHER_ERROR_FLAG_A_SUMMARY_OUT));

// file: dv/cfsb_host_model.sv
// Host controller model issuing byte reads, writes, clears and mask writes.
// Assumes a read is answered by a one-cycle valid pulse.
`timescale 1ns/1ns
module cfsb_host_model (
  input  wire logic       clk_in,       // Clock
  input  wire logic       rd_valid_in,  // Read valid
  input  wire logic [7:0] rd_data_in,   // Read byte
  output logic            rd_stb_out,   // Read strobe
  output logic            wr_stb_out,   // Write strobe
  output logic            clr_out,      // Global clear
  output logic            mask_stb_out, // Mask strobe
  output logic [7:0]      cmd_out,      // Code
  output logic [7:0]      data_out      // Byte
);
  initial begin
    {rd_stb_out, wr_stb_out, clr_out, mask_stb_out} = 4'h0;
    cmd_out  = 8'h00;
    data_out = 8'h00;
  end
  // One byte per request; released lines show the inverse
  task automatic send(input logic [1:0] kind, input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_in);
    cmd_out      <= c;
    data_out     <= d;
    wr_stb_out   <= kind == 2'h1;
    clr_out      <= kind == 2'h2;
    mask_stb_out <= kind == 2'h3;
    @(posedge clk_in);
    {wr_stb_out, clr_out, mask_stb_out} <= 3'h0;
    cmd_out  <= ~c;
    data_out <= ~d;
  endtask
  task automatic read(input logic [7:0] c, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    rd_stb_out <= 1'b1;
    cmd_out    <= c;
    @(posedge clk_in);
    rd_stb_out <= 1'b0;
    cmd_out    <= ~c;
    do begin
      @(negedge clk_in);
      n++;
    end while (rd_valid_in !== 1'b1 && n < 4);
    // A missing answer hands back unknowns, which the bench counts
    d = (rd_valid_in === 1'b1) ? rd_data_in : 8'hXX;
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the fault status bank.
// Assumes the host model drives the register side; events come from here.
`timescale 1ns/1ns
module tb_top
  import cfsb_pkg::*;
;
  localparam int EV_REG [15] = '{0, 0, 0, 1, 1, 1, 2, 2, 3, 3, 3, 3, 3, 3, 3};
  localparam int EV_BIT [15] = '{7, 5, 4, 7, 6, 5, 7, 6, 7, 6, 5, 4, 3, 1, 1};
  logic        clk, nrst, above, aux, sec, rd_stb, wr_stb, clr, mstb, valid, alert, summ;
  logic        seen_on;
  logic [7:0]  cmd, data, rdata, d;
  logic [14:0] ev;
  logic [7:0]  exp_r [4];
  logic [7:0]  msk [4];
  logic [31:0] seed;
  int          mismatches, check_count;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  cfsb_bank dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .WR_STB_IN(wr_stb), .RD_STB_IN(rd_stb),
    .CMD_CODE_IN(cmd), .WR_DATA_IN(data), .CLEAR_FAULTS_IN(clr), .MASK_WR_CODE_IN(cmd),
    .MASK_WR_DATA_IN(data), .MASK_WR_STB_IN(mstb), .OUT_OC_FAULT_IN(ev[0]),
    .OUT_OC_WARN_IN(ev[1]), .OUT_UC_FAULT_IN(ev[2]), .IN_OV_FAULT_IN(ev[3]),
    .IN_OV_WARN_IN(ev[4]), .IN_UV_WARN_IN(ev[5]), .INPUT_ABOVE_ON_IN(above),
    .AUX_FIVE_UVLO_IN(aux), .OT_FAULT_IN(ev[6]), .OT_WARN_IN(ev[7]), .BAD_COMMAND_IN(ev[8]),
    .BAD_DATA_IN(ev[9]), .PEC_FAIL_IN(ev[10]), .MEM_ERROR_IN(ev[11]), .CORE_ERROR_IN(ev[12]),
    .OTHER_OTHER_ERROR_FLAG_A_ERROR_IN(ev[13]), .BACK_CHANNEL_ERR_IN(ev[14]), .IS_SECONDARY_IN(sec),
    .RD_DATA_OUT(rdata), .RD_VALID_OUT(valid), .ALERT_OUT(alert), .OTHER_ERROR_FLAG_A_SUMMARY_OUT(summ));
  cfsb_host_model u_host (.clk_in(clk), .rd_valid_in(valid), .rd_data_in(rdata),
    .rd_stb_out(rd_stb), .wr_stb_out(wr_stb), .clr_out(clr), .mask_stb_out(mstb),
    .cmd_out(cmd), .data_out(data));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] exp_read(input int r);
    return (r == 1) ? exp_r[1] | {4'h0, ~above | aux, 3'h0} : exp_r[r];
  endfunction
  function automatic logic alert_exp();
    logic [7:0] in_m;
    in_m = seen_on ? 8'hE0 : 8'hC0;
    return |((exp_r[0] & ~msk[0]) | (exp_r[1] & ~msk[1] & in_m) | (exp_r[2] & ~msk[2])
             | (exp_r[3] & ~msk[3]));
  endfunction
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Stimulus and expectation helpers
  // ----------------------------------------------------------------
  task automatic check_all();
    for (int r = 0; r < 4; r++) begin
      u_host.read(CMD_OUT_CURRENT + 8'(r), d);
      chk("status", d, exp_read(r));
    end
    u_host.read(8'h7F, d);
    chk("unmapped", d, 8'h00);
    repeat (3) @(negedge clk);
    chk("alert", {7'h00, alert}, {7'h00, alert_exp()});
    chk("summary", {7'h00, summ}, {7'h00, |exp_r[3]});
  endtask
  task automatic pulse(input logic [14:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 15'h0000;
    for (int i = 0; i < 15; i++)
      if (v[i] && (i != 14 || sec))
        exp_r[EV_REG[i]][EV_BIT[i]] = 1'b1;
  endtask
  task automatic wr(input int r, input logic [7:0] v);
    u_host.send(2'h1, CMD_OUT_CURRENT + 8'(r), v);
    exp_r[r] = exp_r[r] & ~v;
  endtask
  task automatic set_mask(input int r, input logic [7:0] v);
    u_host.send(2'h3, CMD_OUT_CURRENT + 8'(r), v);
    msk[r] = v;
  endtask
  task automatic wait_sync(input logic a, input logic u);
    @(posedge clk);
    above <= a;
    aux   <= u;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, above, aux, sec, seen_on} = 5'h00;
    ev          = 15'h0000;
    seed        = 32'h0000004E;
    exp_r       = '{default: 8'h00};
    msk         = '{default: 8'h00};
    mismatches  = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    check_all();
    pulse(15'h0020);
    check_all();
    wr(1, 8'hFF);
    wait_sync(1'b1, 1'b0);
    seen_on = 1'b1;
    check_all();
    wait_sync(1'b1, 1'b1);
    check_all();
    wait_sync(1'b1, 1'b0);
    for (int i = 0; i < 15; i++) begin
      pulse(15'h0001 << i);
      wr(EV_REG[i], 8'h00);
      check_all();
      wr(EV_REG[i], 8'hFF);
      check_all();
    end
    pulse(15'h0040);
    set_mask(2, 8'h80);
    check_all();
    set_mask(2, 8'h00);
    check_all();
    for (int k = 0; k < 40; k++) begin
      seed = xs(seed);
      @(posedge clk);
      sec <= seed[20];
      pulse(seed[14:0]);
      set_mask(int'(seed[22:21]), seed[31:24]);
      wr(int'(seed[17:16]), seed[30:23]);
      if (seed[15]) begin
        u_host.send(2'h2, 8'h00, 8'h00);
        exp_r = '{default: 8'h00};
      end
      check_all();
    end
    @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    exp_r = '{default: 8'h00};
    msk   = '{default: 8'h00};
    repeat (8) @(posedge clk);
    check_all();
    stop_test();
  end
endmodule
